// *** design/urab_defines.svh ***
`ifndef URAB_DEFINES_SVH
`define URAB_DEFINES_SVH

// register byte offsets
`define URAB_OFF_REQ     8'h00
`define URAB_OFF_VALUE   8'h04
`define URAB_OFF_ARB     8'h08
`define URAB_OFF_WDATA   8'h0C
`define URAB_OFF_STAT    8'h10
`define URAB_OFF_MASK    8'h14

// core_read_request fields
`define URAB_REQ_BIT     31
`define URAB_ABORT_BIT   30
`define URAB_ADR_HI      9
`define URAB_ADR_LO      2

// dma_arbiter_setting fields
`define URAB_ARB_EN      31
`define URAB_ARB_MODE    28
`define URAB_PRI_W1_LO   12
`define URAB_PRI_W0_LO   8
`define URAB_PRI_R1_LO   4
`define URAB_PRI_R0_LO   0

// interrupt status / mask fields
`define URAB_INT_RD      0
`define URAB_INT_WR      1
`define URAB_INT_AB      2
`define URAB_INT_W       3

// reset values
`define URAB_VALUE_RST   16'h0000
`define URAB_ADR_RST     8'h00
`define URAB_WDATA_RST   16'h0000
`define URAB_INT_RST     3'h0
`define URAB_PRI_RST     2'h0

`endif

// *** design/urab_pkg.sv ***
package urab_pkg;

  typedef enum logic [1:0] {
    URAB_IDLE  = 2'b00,
    URAB_READ  = 2'b01,
    URAB_WRITE = 2'b10
  } urab_state_t;

  // request toward the usb device core register port
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [9:0]  addr;
    logic [15:0] wdata;
  } urab_core_req_t;

  // answer from the usb device core register port
  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } urab_core_rsp_t;

  // arbiter setting; pri index 0 write0, 1 write1, 2 read0, 3 read1
  typedef struct packed {
    logic            en;
    logic            mode;
    logic [3:0][1:0] pri;
  } urab_arb_cfg_t;

endpackage : urab_pkg

// *** design/urab_arbiter.sv ***
`timescale 1ns/1ps
module urab_arbiter (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire urab_pkg::urab_arb_cfg_t cfg,
  input  wire logic [3:0]              dma_req,
  output logic [3:0]                   dma_gnt
);
  import urab_pkg::*;

  logic [3:0] next_gnt;
  logic [1:0] last;
  logic [1:0] idx;
  logic [2:0] best;
  logic       found;

  always_comb begin
    next_gnt = 4'h0;
    idx      = 2'h0;
    best     = 3'h4;
    found    = 1'b0;
    if (cfg.mode) begin
      // lowest code wins; ties go to the lower index
      for (int i = 0; i < 4; i++) begin
        if (dma_req[i] && ({1'b0, cfg.pri[i]} < best)) begin
          best = {1'b0, cfg.pri[i]};
          idx  = i[1:0];
          found = 1'b1;
        end
      end
    end else begin
      // rotate from the one after the last winner, priorities unused
      for (int k = 4; k >= 1; k--) begin
        if (dma_req[2'(last + k[1:0])]) begin
          idx   = 2'(last + k[1:0]);
          found = 1'b1;
        end
      end
    end
    if (found) begin
      next_gnt[idx] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dma_gnt <= 4'h0;
      last    <= 2'h3;
    end else begin
      dma_gnt <= cfg.en ? next_gnt : 4'h0;
      if (cfg.en && found) begin
        last <= idx;
      end
    end
  end

  a_arb_blocked : assert property (@(posedge hclk) disable iff (!hresetn)
    !cfg.en |=> dma_gnt == 4'h0)
    else $error("grant while arbiter disabled");

  a_fixed_order : assert property (@(posedge hclk) disable iff (!hresetn)
    (cfg.en && cfg.mode && dma_req[0] && dma_req[1] && cfg.pri[0] < cfg.pri[1])
      |=> !dma_gnt[1])
    else $error("lower priority master granted");

  a_rr_rotates : assert property (@(posedge hclk) disable iff (!hresetn)
    (cfg.en && !cfg.mode && dma_req == 4'hF && dma_gnt != 4'h0)
      |=> dma_gnt != $past(dma_gnt))
    else $error("round robin did not rotate");

endmodule : urab_arbiter

// *** design/urab_bridge.sv ***
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "urab_defines.svh"

module urab_bridge (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic [31:0]                   hrdata,
  output urab_pkg::urab_core_req_t      core_req,
  input  wire urab_pkg::urab_core_rsp_t core_rsp,
  input  wire logic [3:0]               dma_req,
  output logic [3:0]                    dma_gnt,
  output logic                          irq
);
  import urab_pkg::*;

  // bus capture
  logic        dp_wr;
  logic [7:0]  dp_addr;

  // register state
  urab_state_t     state;
  urab_state_t     next_state;
  logic            core_access_abort_bit;
  logic [7:0]      core_address_field;
  logic [15:0]     core_read_data;
  logic [15:0]     core_write_data;
  urab_arb_cfg_t   arb_cfg;
  logic [`URAB_INT_W-1:0] interrupt_status_register;
  logic [`URAB_INT_W-1:0] int_mask;
  logic [`URAB_INT_W-1:0] int_set;

  // address phase and decode
  wire        addr_phase = hsel & htrans[1] & hready;
  wire        wr_req     = dp_wr && (dp_addr == `URAB_OFF_REQ);
  wire        wr_arb     = dp_wr && (dp_addr == `URAB_OFF_ARB);
  wire        wr_wdata   = dp_wr && (dp_addr == `URAB_OFF_WDATA);
  wire        wr_stat    = dp_wr && (dp_addr == `URAB_OFF_STAT);
  wire        wr_mask    = dp_wr && (dp_addr == `URAB_OFF_MASK);
  wire [7:0]  rd_addr    = haddr[7:0];
  wire        rd_en      = addr_phase && !hwrite;

  // access control
  wire        idle        = (state == URAB_IDLE);
  wire        abort_wr    = wr_req && hwdata[`URAB_ABORT_BIT];
  wire        start_read  = wr_req && hwdata[`URAB_REQ_BIT] && idle && !abort_wr;
  wire        start_write = wr_wdata && idle;
  wire        read_done   = (state == URAB_READ) && core_rsp.ack && !abort_wr;
  wire        write_done  = (state == URAB_WRITE) && core_rsp.ack && !abort_wr;
  wire        core_read_request_bit = !idle;
  wire        core_read_done_flag =
                interrupt_status_register[`URAB_INT_RD];

  // register images for read back
  wire [31:0] req_image   = {core_read_request_bit, core_access_abort_bit, 20'h00000,
                             core_address_field, 2'h0};
  wire [31:0] value_image = {16'h0000, core_read_data};
  wire [31:0] arb_image   = {arb_cfg.en, 2'h0, arb_cfg.mode, 14'h0000,
                             arb_cfg.pri[1], 2'h0, arb_cfg.pri[0],
                             2'h0, arb_cfg.pri[3], 2'h0, arb_cfg.pri[2]};
  wire [31:0] rd_mux =
    (rd_addr == `URAB_OFF_REQ)   ? req_image :
    (rd_addr == `URAB_OFF_VALUE) ? value_image :
    (rd_addr == `URAB_OFF_ARB)   ? arb_image :
    (rd_addr == `URAB_OFF_WDATA) ? {16'h0000, core_write_data} :
    (rd_addr == `URAB_OFF_STAT)  ? {29'h0000000, interrupt_status_register} :
    (rd_addr == `URAB_OFF_MASK)  ? {29'h0000000, int_mask} :
                                   32'h00000000;

  // zero-wait slave, always OKAY; unmapped reads give zero, writes dropped
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_wr   <= addr_phase && hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  // read data sampled in the address phase; the master idles between
  // transfers so a write never lands between capture and use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_en) begin
      hrdata <= rd_mux;
    end
  end

  // access sequencer
  always_comb begin
    next_state = state;
    case (state)
      URAB_IDLE: begin
        if (start_read) begin
          next_state = URAB_READ;
        end else if (start_write) begin
          next_state = URAB_WRITE;
        end
      end
      URAB_READ: begin
        if (abort_wr || core_rsp.ack) begin
          next_state = URAB_IDLE;
        end
      end
      URAB_WRITE: begin
        if (abort_wr || core_rsp.ack) begin
          next_state = URAB_IDLE;
        end
      end
      default: begin
        next_state = URAB_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= URAB_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // abort stays one cycle: the cancel finishes in that same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_access_abort_bit <= 1'b0;
    end else begin
      core_access_abort_bit <= abort_wr;
    end
  end

  // target address held stable while an access is running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_address_field <= `URAB_ADR_RST;
    end else if (wr_req && idle && !abort_wr) begin
      core_address_field <= hwdata[`URAB_ADR_HI:`URAB_ADR_LO];
    end
  end

  // a cancelled read leaves the old value; nothing is promised about it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_read_data <= `URAB_VALUE_RST;
    end else if (read_done) begin
      core_read_data <= core_rsp.rdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_write_data <= `URAB_WDATA_RST;
    end else if (start_write) begin
      core_write_data <= hwdata[15:0];
    end
  end

  assign core_req = '{valid: !idle,
                      write: (state == URAB_WRITE),
                      addr:  {core_address_field, 2'h0},
                      wdata: core_write_data};

  // arbiter settings: mode and priorities locked while enabled
  wire arb_unlocked = wr_arb && !arb_cfg.en;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arb_cfg <= '{en: 1'b0, mode: 1'b0, pri: {4{`URAB_PRI_RST}}};
    end else begin
      if (wr_arb) begin
        arb_cfg.en <= hwdata[`URAB_ARB_EN];
      end
      if (arb_unlocked) begin
        arb_cfg.mode   <= hwdata[`URAB_ARB_MODE];
        arb_cfg.pri[0] <= hwdata[`URAB_PRI_W0_LO +: 2];
        arb_cfg.pri[1] <= hwdata[`URAB_PRI_W1_LO +: 2];
        arb_cfg.pri[2] <= hwdata[`URAB_PRI_R0_LO +: 2];
        arb_cfg.pri[3] <= hwdata[`URAB_PRI_R1_LO +: 2];
      end
    end
  end

  urab_arbiter u_arbiter (
    .hclk    (hclk),
    .hresetn (hresetn),
    .cfg     (arb_cfg),
    .dma_req (dma_req),
    .dma_gnt (dma_gnt)
  );

  // interrupts: set wins over a same-cycle write-one-to-clear
  assign int_set = {abort_wr && !idle, write_done, read_done};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_status_register <= `URAB_INT_RST;
      int_mask                  <= `URAB_INT_RST;
    end else begin
      interrupt_status_register <= (interrupt_status_register &
        ~(wr_stat ? hwdata[`URAB_INT_W-1:0] : `URAB_INT_RST)) | int_set;
      if (wr_mask) begin
        int_mask <= hwdata[`URAB_INT_W-1:0];
      end
    end
  end

  assign irq = |(interrupt_status_register & int_mask);

  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_read_launch : assert property (
    start_read |=> core_req.valid && !core_req.write &&
                   core_req.addr == {$past(hwdata[`URAB_ADR_HI:`URAB_ADR_LO]), 2'h0})
    else $error("read request not issued");

  a_read_finish : assert property (
    read_done |=> !core_read_request_bit && core_read_done_flag &&
                  core_read_data == $past(core_rsp.rdata))
    else $error("read completion not reflected");

  a_write_busy : assert property (
    start_write |=> core_read_request_bit throughout (core_req.write [*1])
      ##0 core_req.valid)
    else $error("busy not shown during write");

  a_abort_cancel : assert property (
    (abort_wr && !idle) |=> !core_req.valid && !core_read_request_bit &&
                            core_access_abort_bit)
    else $error("abort did not cancel access");

  a_abort_selfclr : assert property (
    abort_wr ##1 !abort_wr |-> ##1 !core_access_abort_bit)
    else $error("abort bit did not clear");

  a_value_hold : assert property (
    !read_done |=> core_read_data == $past(core_read_data))
    else $error("read value changed without a read");

  a_value_upper : assert property (
    (rd_en && rd_addr == `URAB_OFF_VALUE) |=> hrdata[31:16] == 16'h0000 &&
      hrdata[15:0] == $past(core_read_data))
    else $error("read value layout wrong");

  a_arb_lock : assert property (
    (wr_arb && arb_cfg.en) |=> $stable(arb_cfg.mode) && $stable(arb_cfg.pri))
    else $error("arbiter fields written while enabled");

  a_irq_level : assert property (
    (interrupt_status_register & int_mask) != `URAB_INT_RST |-> irq)
    else $error("interrupt not raised");

  a_stat_setwins : assert property (
    (read_done && wr_stat && hwdata[`URAB_INT_RD]) |=> core_read_done_flag)
    else $error("read done lost to clear");

  a_abort_stops : assert property (
    abort_wr |=> !core_req.valid && !core_read_request_bit)
    else $error("access ran on after abort");

  a_abort_flag : assert property (
    (abort_wr && !idle) |=> interrupt_status_register[`URAB_INT_AB])
    else $error("abort of a running access not flagged");

  a_write_launch : assert property (
    start_write |=> core_req.valid && core_req.write &&
      core_req.wdata == $past(hwdata[15:0]) &&
      core_req.addr == {$past(core_address_field), 2'h0})
    else $error("core write not issued");

  a_write_finish : assert property (
    write_done |=> !core_read_request_bit &&
      interrupt_status_register[`URAB_INT_WR])
    else $error("write completion not reflected");

  a_access_holds : assert property (
    (core_req.valid && !core_rsp.ack && !abort_wr) |=> core_req.valid &&
      $stable(core_req.addr) && $stable(core_req.wdata) && $stable(core_req.write))
    else $error("core request moved while waiting");

  a_addr_locked : assert property (
    (wr_req && !idle) |=> $stable(core_address_field))
    else $error("address field written while busy");

  a_no_launch : assert property (
    (idle && !start_read && !start_write) |=> !core_req.valid)
    else $error("core access without request");

  a_busy_image : assert property (
    (rd_en && rd_addr == `URAB_OFF_REQ) |=>
      hrdata[31:30] == {$past(core_req.valid), $past(core_access_abort_bit)})
    else $error("request register image wrong");

  a_stat_clear : assert property (
    (wr_stat && hwdata[`URAB_INT_RD] && !read_done) |=> !core_read_done_flag)
    else $error("read done flag not cleared");

  a_irq_quiet : assert property (
    (interrupt_status_register & int_mask) == `URAB_INT_RST |-> !irq)
    else $error("interrupt raised while masked");

  a_mask_write : assert property (
    wr_mask |=> int_mask == $past(hwdata[`URAB_INT_W-1:0]))
    else $error("mask write lost");

  a_en_write : assert property (
    wr_arb |=> arb_cfg.en == $past(hwdata[`URAB_ARB_EN]))
    else $error("arbiter enable write lost");

  a_arb_unlock : assert property (
    arb_unlocked |=> arb_cfg.mode == $past(hwdata[`URAB_ARB_MODE]) &&
      arb_cfg.pri[1] == $past(hwdata[`URAB_PRI_W1_LO +: 2]) &&
      arb_cfg.pri[3] == $past(hwdata[`URAB_PRI_R1_LO +: 2]))
    else $error("arbiter fields not written while disabled");

endmodule : urab_bridge

// *** testbench/urab_core_model.sv ***
`timescale 1ns/1ps
module urab_core_model (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire urab_pkg::urab_core_req_t core_req,
  input  wire logic [7:0]               delay,
  output urab_pkg::urab_core_rsp_t      core_rsp,
  output logic [9:0]                    wr_addr,
  output logic [15:0]                   wr_data
);
  import urab_pkg::*;
  logic [7:0] cnt;
  logic       done;
  // done blocks a second ack while valid is still up after the first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt      <= 8'h00;
      done     <= 1'b0;
      core_rsp <= '0;
      wr_addr  <= 10'h000;
      wr_data  <= 16'h0000;
    end else begin
      core_rsp.ack   <= 1'b0;
      // data lines toggle outside ack so stale data never looks valid
      core_rsp.rdata <= ~core_rsp.rdata;
      if (!core_req.valid) begin
        cnt  <= 8'h00;
        done <= 1'b0;
      end else if (!done && cnt == delay) begin
        core_rsp.ack   <= 1'b1;
        core_rsp.rdata <= {6'h30, core_req.addr};
        done           <= 1'b1;
        if (core_req.write) begin
          wr_addr <= core_req.addr;
          wr_data <= core_req.wdata;
        end
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule : urab_core_model

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  import urab_pkg::*;
  logic           hclk = 1'b0;
  logic           hresetn = 1'b0;
  logic           hsel = 1'b0;
  logic [31:0]    haddr = 32'h0;
  logic [1:0]     htrans = 2'h0;
  logic           hwrite = 1'b0;
  logic [31:0]    hwdata = 32'h0;
  logic           hreadyout;
  logic           hresp;
  logic [31:0]    hrdata;
  urab_core_req_t core_req;
  urab_core_rsp_t core_rsp;
  logic [3:0]     dma_req = 4'h0;
  logic [3:0]     dma_gnt;
  logic           irq;
  logic [7:0]     dly = 8'h01;
  logic [9:0]     wr_addr;
  logic [15:0]    wr_data;
  logic [31:0]    rd;
  logic [7:0]     adr;
  logic [3:0]     seen;
  int             bad_count = 0;
  int             tests_run = 0;
  always #5 hclk = ~hclk;
  urab_bridge dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .core_req(core_req),
    .core_rsp(core_rsp), .dma_req(dma_req), .dma_gnt(dma_gnt), .irq(irq));
  urab_core_model core (.hclk(hclk), .hresetn(hresetn), .core_req(core_req), .delay(dly),
    .core_rsp(core_rsp), .wr_addr(wr_addr), .wr_data(wr_data));
  task automatic wait_rdy();
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask : wait_rdy
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask : ahb
  // polls the busy bit; the value register is left alone meanwhile
  task automatic wait_idle();
    int n;
    n = 0;
    rd = 32'hFFFF_FFFF;
    while (rd[31] !== 1'b0 && n < 100) begin
      ahb(1'b0, 8'h00, 32'h0);
      n++;
    end
    `CHK(rd[31], 1'b0)
  endtask : wait_idle
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  initial begin
    #200000;
    bad_count++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 7; i++) begin
      ahb(1'b0, 8'(i * 4), 32'h0);
      `CHK(rd, 32'h0)
    end
    // core address fields 0x80 and 0xCD, slow and quick answers
    for (int i = 0; i < 2; i++) begin
      adr = (i == 0) ? 8'h80 : 8'hCD;
      dly <= (i == 0) ? 8'h06 : 8'h01;
      ahb(1'b1, 8'h00, 32'h8000_0000 | {22'h0, adr, 2'b00});
      #1 `CHK(core_req.valid, 1'b1)
      `CHK(core_req.addr, {adr, 2'b00})
      ahb(1'b0, 8'h00, 32'h0);
      `CHK(rd, 32'h8000_0000 | {22'h0, adr, 2'b00})
      wait_idle();
      ahb(1'b0, 8'h04, 32'h0);
      `CHK(rd, {16'h0, 6'h30, adr, 2'b00})
      ahb(1'b0, 8'h10, 32'h0);
      `CHK(rd, 32'h1)
      ahb(1'b1, 8'h10, 32'h1);
    end
    // core write to the held address field
    dly <= 8'h06;
    ahb(1'b1, 8'h00, {22'h0, 8'h90, 2'b00});
    ahb(1'b1, 8'h0C, 32'h0000_1234);
    #1 `CHK(core_req.write, 1'b1)
    ahb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h8000_0240)
    wait_idle();
    `CHK(wr_addr, 10'h240)
    `CHK(wr_data, 16'h1234)
    ahb(1'b0, 8'h04, 32'h0);
    `CHK(rd, {16'h0, 6'h30, 8'hCD, 2'b00})
    ahb(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h2)
    #1 `CHK(irq, 1'b0)
    ahb(1'b1, 8'h14, 32'h2);
    #1 `CHK(irq, 1'b1)
    ahb(1'b1, 8'h10, 32'h7);
    #1 `CHK(irq, 1'b0)
    ahb(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h0)
    // a slow read is cancelled in flight, then a slow write
    dly <= 8'h28;
    ahb(1'b1, 8'h00, 32'h8000_0200);
    ahb(1'b1, 8'h00, 32'h4000_0200);
    ahb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h4000_0200)
    repeat (3) @(posedge hclk);
    #1 `CHK(core_req.valid, 1'b0)
    ahb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h0000_0200)
    ahb(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h4)
    ahb(1'b1, 8'h10, 32'h4);
    ahb(1'b1, 8'h0C, 32'h0000_5A5A);
    #1 `CHK(core_req.write, 1'b1)
    ahb(1'b1, 8'h00, 32'h4000_0000);
    #1 `CHK(core_req.valid, 1'b0)
    ahb(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h4)
    ahb(1'b1, 8'h08, 32'h1000_2310);
    ahb(1'b0, 8'h08, 32'h0);
    `CHK(rd, 32'h1000_2310)
    dma_req <= 4'hF;
    repeat (2) @(posedge hclk);
    #1 `CHK(dma_gnt, 4'h0)
    ahb(1'b1, 8'h08, 32'h9000_2310);
    repeat (2) @(posedge hclk);
    #1 `CHK(dma_gnt, 4'h4)
    ahb(1'b1, 8'h08, 32'h8000_0000);
    ahb(1'b0, 8'h08, 32'h0);
    `CHK(rd, 32'h9000_2310)
    ahb(1'b1, 8'h08, 32'h0);
    ahb(1'b1, 8'h08, 32'h8000_0000);
    seen = 4'h0;
    for (int i = 0; i < 4; i++) begin
      @(posedge hclk);
      #1 `CHK($onehot(dma_gnt), 1'b1)
      seen = seen | dma_gnt;
    end
    `CHK(seen, 4'hF)
    dma_req <= 4'h0;
    conclude();
  end
endmodule : tb_top
